// file: inc/tor_pkg.sv
// shared constants for the timer output recovery block
package tor_pkg;
    localparam int TOR_NUM_CH = 5;
    localparam int TOR_CYC_CH = 3;
    localparam int TOR_MODE_W = 3;
    localparam logic [2:0] TOR_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TOR_MODE_PWM1 = 3'h1;
    localparam logic [2:0] TOR_MODE_PWM2 = 3'h2;
    localparam logic [2:0] TOR_MODE_PHASE = 3'h3;
    localparam logic [2:0] TOR_MODE_CPL = 3'h4;
    localparam logic [2:0] TOR_MODE_RSYNC = 3'h5;
    localparam logic TOR_LVL_LOW = 1'h0;
    localparam logic TOR_LVL_HIGH = 1'h1;
    localparam logic TOR_OUT_RST = 1'h0;
    localparam logic TOR_OE_RST = 1'h0;

    // complementary or reset-synchronous pwm
    function automatic logic tor_is_pair(input logic [2:0] m);
        return (m == TOR_MODE_CPL) || (m == TOR_MODE_RSYNC);
    endfunction

    // modes whose entry from a pair mode forces fixed levels
    function automatic logic tor_is_low_entry(input logic [2:0] m);
        return (m == TOR_MODE_NORMAL) || (m == TOR_MODE_PWM1);
    endfunction
endpackage

// file: inc/tor_chan_if.sv
// per-channel signals between the top and one output stage
`timescale 1ns/1ps
interface tor_chan_if;
    logic count;
    logic pair_run;
    logic plain_run;
    logic halt;
    logic cpl_exit;
    logic rs_exit;
    logic init_a;
    logic init_b;
    logic init_lvl_a;
    logic init_lvl_b;
    logic match_a;
    logic match_b;
    logic mlvl_a;
    logic mlvl_b;
    logic act_pos;
    logic act_neg;
    logic tmr_a;
    logic tmr_b;
    modport top (output count, pair_run, plain_run, halt, cpl_exit,
        rs_exit, init_a, init_b, init_lvl_a, init_lvl_b, match_a, match_b,
        mlvl_a, mlvl_b, act_pos, act_neg, input tmr_a, tmr_b);
    modport chan (input count, pair_run, plain_run, halt, cpl_exit,
        rs_exit, init_a, init_b, init_lvl_a, init_lvl_b, match_a, match_b,
        mlvl_a, mlvl_b, act_pos, act_neg, output tmr_a, tmr_b);
endinterface

// file: src/tor_chan.sv
// timer output levels of one channel (a = positive, b = negative phase)
`timescale 1ns/1ps
module tor_chan
    import tor_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    tor_chan_if.chan bus
);
    logic tmr_a_q;
    logic tmr_b_q;

    // first matching cause wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tmr_a_q <= TOR_OUT_RST; // R1
        end else if (bus.cpl_exit || bus.rs_exit) begin
            tmr_a_q <= TOR_LVL_LOW; // R6 R7
        end else if (bus.halt) begin
            tmr_a_q <= ~bus.act_pos; // R4 R5
        end else if (bus.pair_run && bus.count && bus.match_a) begin
            tmr_a_q <= bus.act_pos; // R16 R13
        end else if (bus.pair_run && bus.count && bus.match_b) begin
            tmr_a_q <= ~bus.act_pos; // R16
        end else if (bus.init_a) begin
            tmr_a_q <= bus.init_lvl_a; // R10
        end else if (bus.plain_run && bus.count && bus.match_a) begin
            tmr_a_q <= bus.mlvl_a; // R15
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tmr_b_q <= TOR_OUT_RST; // R1
        end else if (bus.cpl_exit) begin
            tmr_b_q <= TOR_LVL_LOW; // R6
        end else if (bus.rs_exit) begin
            tmr_b_q <= TOR_LVL_HIGH; // R7
        end else if (bus.halt) begin
            tmr_b_q <= ~bus.act_neg; // R4 R5
        end else if (bus.pair_run && bus.count && bus.match_a) begin
            tmr_b_q <= ~bus.act_neg; // R16
        end else if (bus.pair_run && bus.count && bus.match_b) begin
            tmr_b_q <= bus.act_neg; // R16
        end else if (bus.init_b) begin
            tmr_b_q <= bus.init_lvl_b; // R9 R10
        end else if (bus.plain_run && bus.count && bus.match_b) begin
            tmr_b_q <= bus.mlvl_b; // R15
        end
    end

    assign bus.tmr_a = tmr_a_q;
    assign bus.tmr_b = tmr_b_q;
endmodule

// file: src/tor_top.sv
// timer output stage with error stop and restart behaviour
// How it works
// R1: after reset outputs low, pins undriven
// R2: software moves faulty pins to port output
// R3: software then clears counter start bits
// R4: complementary halt loads its initial output value
// R5: reset-synchronous halt loads its initial value
// R6: complementary to normal/pwm1 drives all low
// R7: reset-sync exit: positive low, negative high
// R8: complementary after reset-sync clears cyclic pin
// R9: pwm1 pin init skips the b side
// R10: pwm2 pin init skips cycle register pin
// R11: pair restart: disable, levels, mode, enable
// R12: new complementary values go via normal mode
// R13: same pair mode restart resumes on match
// R14: plain restart: mode, init pins, select, start
// R15: compare match drives the configured level
// R16: running complementary mode toggles on matches
// R17: forced levels reach pins only when selected
`timescale 1ns/1ps
module tor_top
    import tor_pkg::*;
#(
    parameter int NUM_CH = TOR_NUM_CH,
    parameter int CYC_CH = TOR_CYC_CH
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [TOR_MODE_W-1:0] mode_i,
    input wire logic [NUM_CH-1:0] count_i,
    input wire logic [NUM_CH-1:0] tmr_sel_i,
    input wire logic [NUM_CH-1:0] port_dir_i,
    input wire logic [NUM_CH-1:0] port_data_a_i,
    input wire logic [NUM_CH-1:0] port_data_b_i,
    input wire logic [NUM_CH-1:0] out_en_i,
    input wire logic act_pos_i,
    input wire logic act_neg_i,
    input wire logic cyc_en_i,
    input wire logic [NUM_CH-1:0] cyc_is_b_i,
    input wire logic init_we_i,
    input wire logic [NUM_CH-1:0] init_lvl_a_i,
    input wire logic [NUM_CH-1:0] init_lvl_b_i,
    input wire logic [NUM_CH-1:0] mlvl_a_i,
    input wire logic [NUM_CH-1:0] mlvl_b_i,
    input wire logic [NUM_CH-1:0] match_a_i,
    input wire logic [NUM_CH-1:0] match_b_i,
    output logic [NUM_CH-1:0] pin_a_o,
    output logic [NUM_CH-1:0] pin_a_oe_o,
    output logic [NUM_CH-1:0] pin_b_o,
    output logic [NUM_CH-1:0] pin_b_oe_o,
    output logic cyc_o,
    output logic cyc_oe_o
);
    logic [TOR_MODE_W-1:0] mode_q;
    logic [NUM_CH-1:0] count_q;
    logic [NUM_CH-1:0] halt;
    logic [NUM_CH-1:0] cpl_exit;
    logic [NUM_CH-1:0] rs_exit;
    logic [NUM_CH-1:0] init_a;
    logic [NUM_CH-1:0] init_b;
    logic [NUM_CH-1:0] ta;
    logic [NUM_CH-1:0] tb;
    logic pair_run;
    logic plain_run;
    logic cyc_clr;
    logic cyc_q;
    logic cyc_oe_q;

    assign pair_run = tor_is_pair(mode_i);
    assign plain_run = !pair_run;
    assign cyc_clr = (mode_i == TOR_MODE_CPL) && (mode_q == TOR_MODE_RSYNC);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= TOR_MODE_NORMAL;
        end else begin
            mode_q <= mode_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_i;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            tor_chan_if ch_if ();
            // a falling start bit in a pair mode is a halt
            assign halt[i] = count_q[i] && !count_i[i] && pair_run; // R3 R4 R5
            assign cpl_exit[i] = !count_i[i] && (mode_q == TOR_MODE_CPL) &&
                tor_is_low_entry(mode_i); // R6
            assign rs_exit[i] = !count_i[i] && (mode_q == TOR_MODE_RSYNC) &&
                tor_is_low_entry(mode_i); // R7
            assign init_a[i] = init_we_i && !((mode_i == TOR_MODE_PWM2) &&
                !cyc_is_b_i[i]); // R10
            assign init_b[i] = init_we_i && (mode_i != TOR_MODE_PWM1) &&
                !((mode_i == TOR_MODE_PWM2) && cyc_is_b_i[i]); // R9 R10
            assign ch_if.count = count_i[i];
            assign ch_if.pair_run = pair_run;
            assign ch_if.plain_run = plain_run;
            assign ch_if.halt = halt[i];
            assign ch_if.cpl_exit = cpl_exit[i];
            assign ch_if.rs_exit = rs_exit[i];
            assign ch_if.init_a = init_a[i];
            assign ch_if.init_b = init_b[i];
            assign ch_if.init_lvl_a = init_lvl_a_i[i];
            assign ch_if.init_lvl_b = init_lvl_b_i[i];
            assign ch_if.match_a = match_a_i[i];
            assign ch_if.match_b = match_b_i[i];
            assign ch_if.mlvl_a = mlvl_a_i[i];
            assign ch_if.mlvl_b = mlvl_b_i[i];
            assign ch_if.act_pos = act_pos_i;
            assign ch_if.act_neg = act_neg_i;
            assign ta[i] = ch_if.tmr_a;
            assign tb[i] = ch_if.tmr_b;
            tor_chan u_chan (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .bus(ch_if.chan)
            );
        end
    endgenerate

    // pin mux: timer levels only when the timer function is selected
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_a_o <= '0;
            pin_b_o <= '0;
            pin_a_oe_o <= '0; // R1
            pin_b_oe_o <= '0;
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (tmr_sel_i[k]) begin
                    pin_a_o[k] <= ta[k]; // R17
                    pin_b_o[k] <= tb[k];
                    pin_a_oe_o[k] <= out_en_i[k];
                    pin_b_oe_o[k] <= out_en_i[k];
                end else begin
                    pin_a_o[k] <= port_data_a_i[k]; // R2 R17
                    pin_b_o[k] <= port_data_b_i[k];
                    pin_a_oe_o[k] <= port_dir_i[k];
                    pin_b_oe_o[k] <= port_dir_i[k];
                end
            end
        end
    end

    // cyclic output toggles on the cycle channel's a match in complementary mode
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_q <= TOR_OUT_RST;
        end else if (cyc_clr) begin
            cyc_q <= TOR_LVL_LOW; // R8
        end else if ((mode_i == TOR_MODE_CPL) && cyc_en_i &&
                count_i[CYC_CH] && match_a_i[CYC_CH]) begin
            cyc_q <= ~cyc_q; // R16
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_oe_q <= TOR_OE_RST;
        end else begin
            cyc_oe_q <= cyc_en_i && tmr_sel_i[CYC_CH] && out_en_i[CYC_CH];
        end
    end

    assign cyc_o = cyc_q;
    assign cyc_oe_o = cyc_oe_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_undriven_pin: assert property ( // R1
        !tmr_sel_i[0] && !port_dir_i[0] |=> !pin_a_oe_o[0] && !pin_b_oe_o[0])
        else $error("unselected pin is driven");
    a_halt_initial: assert property ( // R4
        halt[0] |=> ta[0] == !$past(act_pos_i) && tb[0] == !$past(act_neg_i))
        else $error("halt did not load the initial value");
    a_cpl_exit_low: assert property ( // R6
        cpl_exit[0] |=> !ta[0] && !tb[0])
        else $error("leaving complementary mode did not drive low");
    a_rs_exit_level: assert property ( // R7
        rs_exit[0] |=> !ta[0] && tb[0])
        else $error("leaving reset-sync mode gave wrong levels");
    a_cyc_pin_low: assert property ( // R8
        cyc_clr |=> !cyc_o)
        else $error("cyclic pin not cleared");
    a_pwm1_b_kept: assert property ( // R9
        init_we_i && mode_i == TOR_MODE_PWM1 && !match_b_i[0] &&
        !cpl_exit[0] && !rs_exit[0] |=> $stable(tb[0]))
        else $error("pwm1 init touched the b side");
    a_pwm2_cyc_kept: assert property ( // R10
        init_we_i && mode_i == TOR_MODE_PWM2 && !cyc_is_b_i[0] &&
        !match_a_i[0] |=> $stable(ta[0]))
        else $error("pwm2 init touched the cycle pin");
    a_match_level: assert property ( // R15
        plain_run && count_i[0] && match_a_i[0] && !init_a[0] &&
        !cpl_exit[0] && !rs_exit[0] |=> ta[0] == $past(mlvl_a_i[0]))
        else $error("compare match level not driven");
    a_cpl_wave: assert property ( // R16
        pair_run && count_i[0] && match_a_i[0] |=>
        ta[0] == $past(act_pos_i) && tb[0] == !$past(act_neg_i))
        else $error("complementary waveform wrong on match");
    a_pin_follow: assert property ( // R17
        tmr_sel_i[0] |=> pin_a_o[0] == $past(ta[0]) &&
        pin_b_o[0] == $past(tb[0]) && pin_a_oe_o[0] == $past(out_en_i[0]))
        else $error("timer level not on pin");
    a_port_follow: assert property ( // R17
        !tmr_sel_i[0] |=> pin_a_o[0] == $past(port_data_a_i[0]) &&
        pin_a_oe_o[0] == $past(port_dir_i[0]))
        else $error("port data not on pin");

    c_halt_cpl: cover property (halt[0] && mode_i == TOR_MODE_CPL);
    c_rs_exit: cover property (rs_exit[0]);
    c_cyc_clear: cover property (cyc_clr ##1 cyc_en_i);
    c_port_then_timer: cover property (!tmr_sel_i[0] ##[1:20] tmr_sel_i[0]);
endmodule

// file: tb/tor_switch_model.sv
// gate drivers of the external power switches on the timer pins
`timescale 1ns/1ps
module tor_switch_model
    import tor_pkg::*;
(
    input wire logic [TOR_NUM_CH-1:0] pin_a_i,
    input wire logic [TOR_NUM_CH-1:0] pin_a_oe_i,
    input wire logic [TOR_NUM_CH-1:0] pin_b_i,
    input wire logic [TOR_NUM_CH-1:0] pin_b_oe_i,
    output logic [TOR_NUM_CH-1:0] gate_a_o,
    output logic [TOR_NUM_CH-1:0] gate_b_o
);
    // gate inputs have pull-downs, so a released pin switches off
    assign gate_a_o = pin_a_oe_i & pin_a_i;
    assign gate_b_o = pin_b_oe_i & pin_b_i;
endmodule

// file: tb/tb_tor_top.sv
// self-checking bench for the timer output recovery block
`timescale 1ns/1ps
module tb_tor_top
    import tor_pkg::*;
;
    localparam int N = TOR_NUM_CH;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [2:0] mode = '0;
    logic [N-1:0] cnt = '0, sel = '0, dir = '0, pda = '0, pdb = '0;
    logic [N-1:0] oen = '1, cib = '0, la = '0, lb = '0, mla = '0;
    logic [N-1:0] mlb = '0, mta = '0, mtb = '0, ea, eb;
    logic ap = 1'b0, an = 1'b0, cen = 1'b0, iwe = 1'b0;
    logic [N-1:0] pa, paoe, pb, pboe, ga, gb;
    logic cyc, cycoe;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'h9cd95fb4;

    tor_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode),
        .count_i(cnt), .tmr_sel_i(sel), .port_dir_i(dir),
        .port_data_a_i(pda), .port_data_b_i(pdb), .out_en_i(oen),
        .act_pos_i(ap), .act_neg_i(an), .cyc_en_i(cen), .cyc_is_b_i(cib),
        .init_we_i(iwe), .init_lvl_a_i(la), .init_lvl_b_i(lb),
        .mlvl_a_i(mla), .mlvl_b_i(mlb), .match_a_i(mta), .match_b_i(mtb),
        .pin_a_o(pa), .pin_a_oe_o(paoe), .pin_b_o(pb), .pin_b_oe_o(pboe),
        .cyc_o(cyc), .cyc_oe_o(cycoe));
    tor_switch_model u_sw (.pin_a_i(pa), .pin_a_oe_i(paoe), .pin_b_i(pb),
        .pin_b_oe_i(pboe), .gate_a_o(ga), .gate_b_o(gb));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [N-1:0] fill(input logic b);
        return {N{b}};
    endfunction

    // init result where keep marks the side that must not be loaded
    function automatic logic [N-1:0] mix(input logic [N-1:0] n,
        input logic [N-1:0] o, input logic [N-1:0] keep);
        return (n & ~keep) | (o & keep);
    endfunction

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [N-1:0] got, input logic [N-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [N-1:0] a, input logic [N-1:0] b);
        cmp(pa, a);
        cmp(pb, b);
        ea = a;
        eb = b;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // 0 match a, 1 match b, 2 pin init write; then let pins settle
    task automatic hit(input int k);
        mta = (k == 0) ? '1 : '0;
        mtb = (k == 1) ? '1 : '0;
        iwe = (k == 2);
        step(1);
        mta = '0;
        mtb = '0;
        iwe = 1'b0;
        step(3);
    endtask

    task automatic run_once();
        reset_n_i = 1'b0;
        {mode, cnt, sel, dir, cen, cib} = '0;
        ap = 1'($random(seed));
        an = 1'($random(seed));
        step(12);
        cmp(pa | pb | paoe | pboe | fill(cyc | cycoe), '0);
        reset_n_i = 1'b1;
        step(2);
        cmp(paoe | pboe | ga | gb, '0);
        mode = TOR_MODE_CPL;
        cnt = '1;
        sel = '1;
        hit(0);
        chk(fill(ap), fill(~an));
        cmp(paoe & pboe, '1);
        hit(1);
        chk(fill(~ap), fill(an));
        sel = '0;
        dir = '1;
        pda = N'($random(seed));
        pdb = N'($random(seed));
        step(3);
        cmp(ga, pda);
        cmp(gb, pdb);
        cnt = '0;
        step(3);
        chk(pda, pdb);
        sel = '1;
        step(3);
        chk(fill(~ap), fill(~an));
        cnt = '1;
        hit(0);
        chk(fill(ap), fill(~an));
        cnt = '0;
        step(3);
        mode = TOR_MODE_NORMAL;
        step(3);
        chk('0, '0);
        la = '1;
        lb = N'($random(seed));
        hit(2);
        chk(la, lb);
        mla = N'($random(seed));
        mlb = N'($random(seed));
        cnt = '1;
        hit(0);
        chk(mla, lb);
        hit(1);
        chk(mla, mlb);
        cnt = '0;
        mode = TOR_MODE_PWM1;
        la = N'($random(seed));
        lb = ~mlb;
        hit(2);
        chk(la, eb);
        mode = TOR_MODE_PWM2;
        cib = N'($random(seed));
        la = N'($random(seed));
        lb = N'($random(seed));
        hit(2);
        chk(mix(la, ea, ~cib), mix(lb, eb, cib));
        mode = TOR_MODE_PHASE;
        la = N'($random(seed));
        lb = N'($random(seed));
        hit(2);
        chk(la, lb);
        mode = TOR_MODE_RSYNC;
        cnt = '1;
        hit(1);
        chk(fill(~ap), fill(an));
        sel = '0;
        cnt = '0;
        step(3);
        sel = '1;
        step(3);
        chk(fill(~ap), fill(~an));
        mode = TOR_MODE_PWM1;
        step(3);
        chk('0, '1);
        // pair restart: outputs of the upper channels off around the mode set
        oen[N-1:TOR_CYC_CH] = '0;
        cen = 1'b1;
        mode = TOR_MODE_CPL;
        step(3);
        cmp(paoe, N'((1 << TOR_CYC_CH) - 1));
        cmp(N'(cycoe), '0);
        oen = '1;
        cnt = '1;
        hit(0);
        cmp(N'(cyc), N'(1'b1));
        cmp(N'(cycoe), N'(1'b1));
        cnt = '0;
        mode = TOR_MODE_RSYNC;
        step(3);
        mode = TOR_MODE_CPL;
        step(3);
        cmp(N'(cyc), '0);
    endtask

    initial begin
        repeat (4) run_once();
        wrap_up();
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule
